// [fail_reset_cfg.svh]
`ifndef FAIL_RESET_CFG_SVH
`define FAIL_RESET_CFG_SVH
// register byte offsets
`define FR_ADDR_MODE        4'h0
`define FR_ADDR_CFG         4'h4
`define FR_ADDR_STATUS      4'h8
// configuration field positions
`define FR_CFG_FORCE        0
`define FR_CFG_DUTY_LO      1
`define FR_CFG_SRST_RO      3
`define FR_CFG_PIN2_LO      4
`define FR_CFG_PIN3_LO      7
`define FR_CFG_THR_LO       10
// reset values and soft-reset mode code
`define FR_RST_FORCE        1'h0
`define FR_RST_DUTY         2'h0
`define FR_RST_SRST_RO      1'h1
`define FR_RST_THR          2'h0
`define FR_RST_MODE_REQ     2'h0
`define FR_MODE_SOFT_RESET  2'h3
// timing
`define FR_CLK_MHZ          40
`define FR_TEST_FILT_US     64
`define FR_TEST_FILT_CYC    (`FR_TEST_FILT_US * `FR_CLK_MHZ)
`define FR_RF_US            10
`define FR_RF_CYC           (`FR_RF_US * `FR_CLK_MHZ)
`define FR_RD_MS            10
`define FR_RD_CYC           (`FR_RD_MS * 1000 * `FR_CLK_MHZ)
`define FR_TICK_US          250
`define FR_TICK_CYC         (`FR_TICK_US * `FR_CLK_MHZ)
`define FR_BLINK_HZ_X100    125
`define FR_BLINK_HALF_TICKS (100000000 / (`FR_BLINK_HZ_X100 * 2 * `FR_TICK_US))
`define FR_PWM_HZ           100
`define FR_PWM_TICKS        (1000000 / (`FR_PWM_HZ * `FR_TICK_US))
`define FR_PWM_DUTY_PCT     20
`define FR_PWM_ON_TICKS     (`FR_PWM_TICKS * `FR_PWM_DUTY_PCT / 100)
`endif

// [fail_reset_pkg.sv]
package fail_reset_pkg;
  typedef enum logic [2:0] {
    MODE_INIT     = 3'h0,
    MODE_NORMAL   = 3'h1,
    MODE_STOP     = 3'h2,
    MODE_SLEEP    = 3'h3,
    MODE_RESTART  = 3'h4,
    MODE_FAILSAFE = 3'h5
  } mode_t;
  typedef enum logic [2:0] {
    PIN_FAIL_OUT = 3'h0,
    PIN_OFF      = 3'h1,
    PIN_WAKE     = 3'h2,
    PIN_LOW_SIDE = 3'h3,
    PIN_HIGH_SIDE= 3'h4
  } pin_cfg_t;
endpackage : fail_reset_pkg

// [fail_reset_outputs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fail_reset_cfg.svh"
module fail_reset_outputs
  import fail_reset_pkg::*;
#(
  parameter int RESET_DELAY_CYC = `FR_RD_CYC,
  parameter int TICK_CYC        = `FR_TICK_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic [2:0]  i_mode,
  input  wire logic        i_failure,
  input  wire logic        i_wd_fail,
  input  wire logic        i_main_regulator_uv,
  input  wire logic        i_pulsed_fail_output_test_pin,
  output logic             o_static_fail_output_o,
  output logic             o_static_fail_output_oe,
  output logic             o_blink_fail_output_o,
  output logic             o_blink_fail_output_oe,
  output logic             o_pulsed_fail_output_test_pin_o,
  output logic             o_pulsed_fail_output_test_pin_oe,
  output logic             o_blink_pin_wake_en,
  output logic             o_pulsed_pin_wake_en,
  output logic             o_test_level,
  output logic             o_reset_output_o,
  output logic             o_reset_output_oe,
  output logic      [1:0]  o_reset_threshold_sel,
  output logic      [1:0]  o_mode_request,
  output logic             o_soft_reset
);
  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  logic rst_meta_reg, rst_n;
  logic [1:0] uv_sync_reg, test_sync_reg;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      uv_sync_reg   <= 2'h3;
      test_sync_reg <= 2'h3;
    end else begin
      uv_sync_reg   <= {uv_sync_reg[0], i_main_regulator_uv};
      test_sync_reg <= {test_sync_reg[0], i_pulsed_fail_output_test_pin};
    end
  end
  wire uv_level   = uv_sync_reg[1];
  wire test_level = test_sync_reg[1];
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  logic        dp_wr_reg;
  logic [3:0]  dp_addr_reg;
  logic        force_reg, srst_ro_reg;
  logic [1:0]  duty_reg, thr_reg, mode_req_reg;
  pin_cfg_t    pin2_reg, pin3_reg;
  logic        ro_low_reg, test_lvl_reg, soft_reg;
  wire mode_t  mode = mode_t'(i_mode);
  wire addr_ph   = i_hsel & i_hready & i_htrans[1];
  wire in_normal = (mode == MODE_NORMAL);
  wire wr_mode   = dp_wr_reg & (dp_addr_reg == `FR_ADDR_MODE);
  wire wr_cfg    = dp_wr_reg & (dp_addr_reg == `FR_ADDR_CFG) & in_normal;
  wire soft_req  = wr_mode & (i_hwdata[1:0] == `FR_MODE_SOFT_RESET)
                 & (in_normal | (mode == MODE_STOP));
  wire fail_active = i_failure | force_reg;
  wire [31:0] cfg_word = {20'h0, thr_reg, pin3_reg, pin2_reg,
                          srst_ro_reg, duty_reg, force_reg};
  wire [31:0] stat_word = {26'h0, mode, test_lvl_reg, ro_low_reg, fail_active};
  wire [31:0] rd_word = (i_haddr[3:0] == `FR_ADDR_MODE)   ? {30'h0, mode_req_reg} :
                        (i_haddr[3:0] == `FR_ADDR_CFG)    ? cfg_word :
                        (i_haddr[3:0] == `FR_ADDR_STATUS) ? stat_word : 32'h0;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 4'h0;
      o_hrdata    <= 32'h0;
    end else begin
      dp_wr_reg   <= addr_ph & i_hwrite & (i_haddr[31:4] == 28'h0);
      dp_addr_reg <= i_haddr[3:0];
      if (addr_ph && !i_hwrite)
        o_hrdata <= (i_haddr[31:4] == 28'h0) ? rd_word : 32'h0;
    end
  end
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      force_reg    <= `FR_RST_FORCE;
      duty_reg     <= `FR_RST_DUTY;
      srst_ro_reg  <= `FR_RST_SRST_RO;
      thr_reg      <= `FR_RST_THR;
      pin2_reg     <= PIN_FAIL_OUT;
      pin3_reg     <= PIN_FAIL_OUT;
      mode_req_reg <= `FR_RST_MODE_REQ;
    end else if (soft_req) begin
      force_reg    <= `FR_RST_FORCE;
      duty_reg     <= `FR_RST_DUTY;
      srst_ro_reg  <= `FR_RST_SRST_RO;
      thr_reg      <= `FR_RST_THR;
      pin2_reg     <= PIN_FAIL_OUT;
      pin3_reg     <= PIN_FAIL_OUT;
      mode_req_reg <= `FR_RST_MODE_REQ;
    end else begin
      if (wr_mode && i_hwdata[1:0] != `FR_MODE_SOFT_RESET)
        mode_req_reg <= i_hwdata[1:0];
      if (wr_cfg) begin
        force_reg   <= i_hwdata[`FR_CFG_FORCE];
        duty_reg    <= i_hwdata[`FR_CFG_DUTY_LO +: 2];
        srst_ro_reg <= i_hwdata[`FR_CFG_SRST_RO];
        pin2_reg    <= pin_cfg_t'(i_hwdata[`FR_CFG_PIN2_LO +: 3]);
        pin3_reg    <= pin_cfg_t'(i_hwdata[`FR_CFG_PIN3_LO +: 3]);
        thr_reg     <= i_hwdata[`FR_CFG_THR_LO +: 2];
      end
    end
  end
  // soft_reg is cleared by itself one cycle later, only a pulse
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) soft_reg <= 1'b0;
    else        soft_reg <= soft_req;
  end
  assign o_soft_reset          = soft_reg;
  assign o_mode_request        = mode_req_reg;
  assign o_reset_threshold_sel = thr_reg;
  // ------------------------------------------------------------
  // test pin filter
  // ------------------------------------------------------------
  logic [11:0] tf_cnt_reg;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tf_cnt_reg   <= 12'h0;
      test_lvl_reg <= 1'b1;
    end else if (test_level == test_lvl_reg) begin
      tf_cnt_reg <= 12'h0;
    end else if (tf_cnt_reg == 12'(`FR_TEST_FILT_CYC - 1)) begin
      tf_cnt_reg   <= 12'h0;
      test_lvl_reg <= test_level;
    end else begin
      tf_cnt_reg <= tf_cnt_reg + 12'h1;
    end
  end
  assign o_test_level = test_lvl_reg;
  // ------------------------------------------------------------
  // blink and pulse waveforms
  // ------------------------------------------------------------
  logic [13:0] pre_reg;
  logic [11:0] blink_reg;
  logic [5:0]  pwm_reg;
  wire tick = (pre_reg == 14'(TICK_CYC - 1));
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg   <= 14'h0;
      blink_reg <= 12'h0;
      pwm_reg   <= 6'h0;
    end else if (!fail_active) begin
      pre_reg   <= 14'h0;
      blink_reg <= 12'h0;
      pwm_reg   <= 6'h0;
    end else begin
      pre_reg <= tick ? 14'h0 : pre_reg + 14'h1;
      if (tick) begin
        blink_reg <= (blink_reg == 12'(2 * `FR_BLINK_HALF_TICKS - 1)) ? 12'h0
                   : blink_reg + 12'h1;
        pwm_reg   <= (pwm_reg == 6'(`FR_PWM_TICKS - 1)) ? 6'h0 : pwm_reg + 6'h1;
      end
    end
  end
  wire blink_on = fail_active & (blink_reg < 12'(`FR_BLINK_HALF_TICKS));
  wire [5:0] pwm_on_ticks = 6'(`FR_PWM_ON_TICKS) >> duty_reg;
  wire pwm_on = fail_active & (pwm_reg < pwm_on_ticks);
  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  function automatic logic [1:0] pin_drive(pin_cfg_t cfg, logic fail_output_force, mode_t md);
    logic off_mode;
    off_mode = (md == MODE_RESTART) || (md == MODE_FAILSAFE);
    case (cfg)
      PIN_FAIL_OUT:  pin_drive = {fail_output_force, 1'b0};
      PIN_LOW_SIDE:  pin_drive = {!off_mode, 1'b0};
      PIN_HIGH_SIDE: pin_drive = {!off_mode, !off_mode};
      default:       pin_drive = 2'h0;
    endcase
  endfunction : pin_drive
  logic [1:0] pin2_drv_reg, pin3_drv_reg;
  logic       static_oe_reg, wake2_reg, wake3_reg;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin2_drv_reg  <= 2'h0;
      pin3_drv_reg  <= 2'h0;
      static_oe_reg <= 1'b0;
      wake2_reg     <= 1'b0;
      wake3_reg     <= 1'b0;
    end else begin
      static_oe_reg <= fail_active;
      pin2_drv_reg  <= pin_drive(pin2_reg, blink_on, mode);
      pin3_drv_reg  <= pin_drive(pin3_reg, pwm_on, mode);
      wake2_reg <= (pin2_reg == PIN_WAKE) && (mode != MODE_FAILSAFE);
      wake3_reg <= (pin3_reg == PIN_WAKE) && (mode != MODE_FAILSAFE);
    end
  end
  assign o_static_fail_output_o           = 1'b0;
  assign o_static_fail_output_oe          = static_oe_reg;
  assign o_blink_fail_output_oe           = pin2_drv_reg[1];
  assign o_blink_fail_output_o            = pin2_drv_reg[0];
  assign o_pulsed_fail_output_test_pin_oe = pin3_drv_reg[1];
  assign o_pulsed_fail_output_test_pin_o  = pin3_drv_reg[0];
  assign o_blink_pin_wake_en              = wake2_reg;
  assign o_pulsed_pin_wake_en             = wake3_reg;
  // ------------------------------------------------------------
  // reset output
  // ------------------------------------------------------------
  // watchdog failure joins undervoltage
  wire rst_event = uv_level | i_wd_fail;
  logic [13:0] rf_cnt_reg;
  logic [19:0] rd_cnt_reg;
  wire rf_done = rst_event & (rf_cnt_reg == 14'(`FR_RF_CYC - 1));
  wire srst_ro = soft_req & srst_ro_reg;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n)          rf_cnt_reg <= 14'h0;
    else if (!rst_event) rf_cnt_reg <= 14'h0;
    else if (!rf_done)   rf_cnt_reg <= rf_cnt_reg + 14'h1;
  end
  // starts low; released only after a full delay without event
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ro_low_reg <= 1'b1;
      rd_cnt_reg <= 20'h0;
    end else if (rf_done || srst_ro) begin
      ro_low_reg <= 1'b1;
      rd_cnt_reg <= 20'h0;
    end else if (ro_low_reg) begin
      if (rst_event)
        rd_cnt_reg <= 20'h0;
      else if (rd_cnt_reg == 20'(RESET_DELAY_CYC - 1))
        ro_low_reg <= 1'b0;
      else
        rd_cnt_reg <= rd_cnt_reg + 20'h1;
    end
  end
  assign o_reset_output_o  = 1'b0;
  assign o_reset_output_oe = ro_low_reg;
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_locked_wr;
    dp_wr_reg && dp_addr_reg == `FR_ADDR_CFG && !in_normal;
  endsequence
  property p_cfg_write;
    wr_cfg && !soft_reg |=> cfg_word[11:0] == $past(i_hwdata[11:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("cfg write lost");
  property p_cfg_locked;
    s_locked_wr ##0 !soft_reg |=> $stable(cfg_word);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("cfg changed");
  property p_fo_together;
    fail_active && pin2_reg == PIN_FAIL_OUT && pin3_reg == PIN_FAIL_OUT
      && $past(!fail_active) |=> o_static_fail_output_oe && o_blink_fail_output_oe
      && o_pulsed_fail_output_test_pin_oe;
  endproperty
  a_fo_together: assert property (p_fo_together) else $error("fail outputs split");
  property p_switch_off;
    (mode == MODE_RESTART || mode == MODE_FAILSAFE) && pin2_reg != PIN_FAIL_OUT
      |=> !o_blink_fail_output_oe;
  endproperty
  a_switch_off: assert property (p_switch_off) else $error("switch on in restart");
  property p_wake_off;
    mode == MODE_FAILSAFE |=> !o_blink_pin_wake_en && !o_pulsed_pin_wake_en;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake in fail-safe");
  property p_test_filter;
    $changed(test_lvl_reg) |-> $past(tf_cnt_reg) == 12'(`FR_TEST_FILT_CYC - 1);
  endproperty
  a_test_filter: assert property (p_test_filter) else $error("test unfiltered");
  property p_ro_cause;
    $rose(ro_low_reg) |-> $past(rf_done) || $past(srst_ro);
  endproperty
  a_ro_cause: assert property (p_ro_cause) else $error("reset without cause");
  property p_ro_release;
    $fell(ro_low_reg) |-> $past(rd_cnt_reg) == 20'(RESET_DELAY_CYC - 1)
      && !$past(rst_event);
  endproperty
  a_ro_release: assert property (p_ro_release) else $error("early release");
  property p_soft_mode;
    o_soft_reset |-> $past(mode) == MODE_NORMAL || $past(mode) == MODE_STOP;
  endproperty
  a_soft_mode: assert property (p_soft_mode) else $error("soft reset bad mode");
  property p_soft_defaults;
    o_soft_reset |-> thr_reg == `FR_RST_THR && srst_ro_reg && !force_reg
      && pin2_reg == PIN_FAIL_OUT;
  endproperty
  a_soft_defaults: assert property (p_soft_defaults) else $error("no defaults");
  property p_soft_no_ro;
    soft_req && !srst_ro_reg && !ro_low_reg && !rf_done |=> !ro_low_reg;
  endproperty
  a_soft_no_ro: assert property (p_soft_no_ro) else $error("soft pulsed reset");
endmodule : fail_reset_outputs
`default_nettype wire

// [fail_pin_world.sv]
`timescale 1ns/10ps
`default_nettype none
module fail_pin_world (
  input  wire logic i_test_oe,
  input  wire logic i_test_o,
  input  wire logic i_ext_low,
  output logic      o_test_pin
);
  // ---------------------------------
  // board side of the pulsed/test pin
  // ---------------------------------
  // driven with i_test_o while enabled, pull-up otherwise
  // board holds pin high
  // the board only pulls low when the bench asks, to exercise the filter
  assign o_test_pin = i_test_oe ? i_test_o : !i_ext_low;
endmodule : fail_pin_world
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fail_reset_cfg.svh"
`define CHECK_EQ(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import fail_reset_pkg::*;
;
  localparam int          RDC   = 50;
  localparam int          TCK   = 10;
  localparam logic [31:0] A_MOD = {28'h0, `FR_ADDR_MODE};
  localparam logic [31:0] A_CFG = {28'h0, `FR_ADDR_CFG};
  localparam logic [31:0] A_ST  = {28'h0, `FR_ADDR_STATUS};
  logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0;
  logic        failure = 1'b0, wd_fail = 1'b0, uv = 1'b0, ext_low = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  mode = MODE_INIT;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, e_v;
  logic [31:0] exp_q[$];
  wire  [31:0] hrdata;
  wire  [1:0]  thr, mreq;
  wire         hready, hresp, st_o, st_oe, bl_o, bl_oe, pu_o, pu_oe, bl_wk, pu_wk;
  wire         tlvl, ro_o, ro_oe, srst, tpin;
  int          n_errors = 0, checked = 0, cyc = 0, n;

  fail_reset_outputs #(.RESET_DELAY_CYC(RDC), .TICK_CYC(TCK)) uut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_mode(mode),
    .i_failure(failure), .i_wd_fail(wd_fail), .i_main_regulator_uv(uv),
    .i_pulsed_fail_output_test_pin(tpin), .o_static_fail_output_o(st_o),
    .o_static_fail_output_oe(st_oe), .o_blink_fail_output_o(bl_o),
    .o_blink_fail_output_oe(bl_oe), .o_pulsed_fail_output_test_pin_o(pu_o),
    .o_pulsed_fail_output_test_pin_oe(pu_oe), .o_blink_pin_wake_en(bl_wk),
    .o_pulsed_pin_wake_en(pu_wk), .o_test_level(tlvl), .o_reset_output_o(ro_o),
    .o_reset_output_oe(ro_oe), .o_reset_threshold_sel(thr), .o_mode_request(mreq),
    .o_soft_reset(srst));

  fail_pin_world pins (.i_test_oe(pu_oe), .i_test_o(pu_o), .i_ext_low(ext_low),
    .o_test_pin(tpin));

  always #12.5 clk = ~clk;

  // ------------------------------
  // read-data watcher and timeout
  // ------------------------------
  always @(posedge clk) begin
    cyc++;
    if (rd_pend && hready === 1'b1) begin
      e_v = exp_q.pop_front();
      `CHECK_EQ(hrdata, e_v)
      `CHECK_EQ(hresp, 1'b0)
    end
    if (hready === 1'b1) rd_pend <= hsel && htrans[1] && !hwrite;
    if (cyc > 60000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
  endtask : cycles

  // single transfer: address phase, then data phase, each closed by hready
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic span(input logic blk, input logic lvl, output int k);
    k = 0;
    while (((blk ? bl_oe : pu_oe) === lvl) && k < 20000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : span

  task automatic ev(input int s, input logic v);
    @(posedge clk);
    if (s == 1) uv <= v;
    else wd_fail <= v;
  endtask : ev

  // -------------
  // main sequence
  // -------------
  initial begin
    void'($urandom(32'h6F54));
    cycles(3);
    rstn <= 1'b1;
    cycles(30); #1;
    `CHECK_EQ(ro_oe, 1'b1)
    cycles(40); #1;
    `CHECK_EQ(ro_oe, 1'b0)
    @(posedge clk) mode <= MODE_NORMAL;
    rd(A_CFG, 32'h8);
    rd(A_ST, 32'hC);
    rd(32'hC, 32'h0);
    for (int c = 0; c < 5; c++) begin
      bus(1'b1, A_CFG, 32'h8 | (c << 4) | (c << 7));
      cycles(2); #1;
      `CHECK_EQ(pu_oe, c >= 3)
      `CHECK_EQ(bl_oe, c >= 3)
      `CHECK_EQ(pu_wk, c == 2)
      `CHECK_EQ(bl_wk, c == 2)
      if (c >= 3) `CHECK_EQ(pu_o, c == 4)
    end
    bus(1'b1, A_CFG, 32'h1A8);
    for (int m = 2; m < 4; m++) begin
      @(posedge clk) mode <= m[2:0];
      bus(1'b1, A_CFG, $urandom | 32'h1);
      rd(A_CFG, 32'h1A8);
      #1;
      `CHECK_EQ(st_oe | bl_wk | pu_oe, 1'b1)
      `CHECK_EQ(st_oe, 1'b0)
    end
    @(posedge clk) mode <= MODE_RESTART;
    failure <= 1'b1;
    cycles(2); #1;
    `CHECK_EQ(bl_wk, 1'b1)
    `CHECK_EQ(pu_oe, 1'b0)
    `CHECK_EQ(st_oe, 1'b1)
    @(posedge clk) mode <= MODE_FAILSAFE;
    cycles(2); #1;
    `CHECK_EQ(bl_wk, 1'b0)
    @(posedge clk) mode <= MODE_NORMAL;
    cycles(2); #1;
    `CHECK_EQ(bl_wk & pu_oe, 1'b1)
    `CHECK_EQ(st_oe, 1'b1)
    rd(A_CFG, 32'h1A8);
    failure <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, A_CFG, 32'h8);
      cycles(2); #1;
      `CHECK_EQ(st_oe, 1'b0)
      bus(1'b1, A_CFG, 32'h9 | (d << 1));
      #1;
      span(1'b0, 1'b0, n);
      `CHECK_EQ(n, 1)
      `CHECK_EQ(st_oe & bl_oe, 1'b1)
      span(1'b0, 1'b1, n);
      `CHECK_EQ(n, (8 >> d) * TCK)
      span(1'b0, 1'b0, n);
      `CHECK_EQ(n, 40 * TCK - (8 >> d) * TCK)
    end
    bus(1'b1, A_CFG, 32'h8);
    bus(1'b1, A_CFG, 32'h9);
    #1;
    span(1'b1, 1'b0, n);
    span(1'b1, 1'b1, n);
    `CHECK_EQ(n, 1600 * TCK)
    span(1'b1, 1'b0, n);
    `CHECK_EQ(n, 1600 * TCK)
    bus(1'b1, A_CFG, 32'h8);
    for (int s = 0; s < 2; s++) begin
      ev(s, 1'b1); cycles(300); ev(s, 1'b0); cycles(5);
      ev(s, 1'b1); cycles(300); #1;
      `CHECK_EQ(ro_oe, 1'b0)
      cycles(150); #1;
      `CHECK_EQ(ro_oe, 1'b1)
      ev(s, 1'b0); cycles(30); #1;
      `CHECK_EQ(ro_oe, 1'b1)
      cycles(40); #1;
      `CHECK_EQ(ro_oe, 1'b0)
    end
    @(posedge clk) ext_low <= 1'b1;
    cycles(2400); #1;
    `CHECK_EQ(tlvl, 1'b1)
    cycles(300); #1;
    `CHECK_EQ(tlvl, 1'b0)
    @(posedge clk) ext_low <= 1'b0;
    cycles(2700); #1;
    `CHECK_EQ(tlvl, 1'b1)
    for (int m = 0; m < 6; m++) begin
      if (m == 1 || m == 2) continue;
      @(posedge clk) mode <= m[2:0];
      bus(1'b1, A_MOD, 32'h3);
      #1;
      `CHECK_EQ(srst, 1'b0)
    end
    @(posedge clk) mode <= MODE_NORMAL;
    bus(1'b1, A_CFG, 32'h808);
    bus(1'b1, A_MOD, 32'h1);
    #1;
    `CHECK_EQ(thr, 2'h2)
    `CHECK_EQ(mreq, 2'h1)
    bus(1'b1, A_MOD, 32'h3);
    #1;
    `CHECK_EQ(srst & ro_oe, 1'b1)
    rd(A_CFG, 32'h8);
    #1;
    `CHECK_EQ(thr, 2'h0)
    cycles(100); #1;
    `CHECK_EQ(ro_oe, 1'b0)
    bus(1'b1, A_CFG, 32'h0);
    @(posedge clk) mode <= MODE_STOP;
    bus(1'b1, A_MOD, 32'h3);
    #1;
    `CHECK_EQ(srst, 1'b1)
    `CHECK_EQ(ro_oe, 1'b0)
    cycles(3);
    conclude();
  end
endmodule : testbench
`default_nettype wire
